// ===== hdl/fabric_gear.sv
`default_nettype none
// Fabric-side bus formatting and 2:1 / 1:2 gearing of the byte path
module fabric_gear
   import gear_pkg::*;
(
   // Clock and control
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              clk_en,
   input  wire logic [1:0]        fabric_width,   // WIDTH_1B, WIDTH_2B, WIDTH_4B
   input  wire logic              internal_two,   // Internal path is two bytes
   // Fabric transmit side
   input  wire logic [BUS_W-1:0]  tx_data,
   input  wire logic              tx_valid,
   output logic                   tx_ready,
   // Internal transmit side
   output logic [HALF_W-1:0]      int_tx_data,
   output logic                   int_tx_valid,
   // Internal receive side
   input  wire logic [HALF_W-1:0] int_rx_data,
   input  wire logic              int_rx_valid,
   // Fabric receive side
   output logic [BUS_W-1:0]       rx_data,
   output logic                   rx_valid,
   // 8b view of transmit slot 2 flags
   output logic                   tx_slot2_disp,
   output logic                   tx_slot2_ctrl
);
   typedef struct packed {
      logic [HALF_W-1:0] hold;      // Second half of a four-byte word
      logic              phase;     // High while the second half is pending
      logic [HALF_W-1:0] itx;
      logic              itx_v;
      logic [BUS_W-1:0]  rx;
      logic              rx_v;
      logic              rdy;
      logic              disp2;
      logic              ctrl2;
   } gear_state_type;

   gear_state_type state_reg, state_next;

   half_if rx_half ();
   logic [BUS_W-1:0] joined;
   logic             joined_v;
   logic             gear4;

   // Gearing only applies when the fabric is four bytes wide
   assign gear4 = (fabric_width == WIDTH_4B);

   // Only pairs go through the joiner; 1- and 2-byte modes bypass it
   assign rx_half.data  = int_rx_data;
   assign rx_half.valid = int_rx_valid && gear4;

   rx_joiner u_join (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .clk_en     (clk_en),
      .half_in    (rx_half),
      .word_out   (joined),
      .word_valid (joined_v)
   );

   // Transmit path, receive bypass and flag extraction
   always_comb begin
      state_next       = state_reg;
      state_next.itx_v = 1'b0;
      state_next.rx_v  = 1'b0;
      if (gear4) begin
         if (state_reg.phase) begin
            // Second half leaves one cycle after the first; fabric stalled
            state_next.itx   = state_reg.hold;
            state_next.itx_v = 1'b1;
            state_next.phase = 1'b0;
            state_next.rdy   = 1'b1;
         end else if (tx_valid && state_reg.rdy) begin
            state_next.itx   = tx_data[HALF_W-1:0];
            state_next.hold  = tx_data[BUS_W-1:HALF_W];
            state_next.itx_v = 1'b1;
            state_next.phase = 1'b1;
            state_next.rdy   = 1'b0;
            state_next.disp2 = tx_data[2*SLOT_W+DISP_POS];
            state_next.ctrl2 = tx_data[2*SLOT_W+CTRL_POS];
         end
         state_next.rx   = joined;
         state_next.rx_v = joined_v;
      end else begin
         state_next.phase = 1'b0;
         state_next.rdy   = 1'b1;
         state_next.disp2 = 1'b0;
         state_next.ctrl2 = 1'b0;
         if (tx_valid) begin
            state_next.itx_v = 1'b1;
            if (fabric_width == WIDTH_1B || !internal_two)
               state_next.itx = {10'h000, tx_data[SLOT_W-1:0]};
            else
               state_next.itx = tx_data[HALF_W-1:0];
         end
         if (int_rx_valid) begin
            state_next.rx_v = 1'b1;
            if (fabric_width == WIDTH_1B || !internal_two)
               state_next.rx = {30'h0, int_rx_data[SLOT_W-1:0]};
            else
               state_next.rx = {20'h0, int_rx_data};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg       <= '0;
         state_reg.phase <= PHASE_RST;
         state_reg.rx    <= BUS_RST;
         state_reg.rdy   <= 1'b1;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   assign int_tx_data   = state_reg.itx;
   assign int_tx_valid  = state_reg.itx_v;
   assign rx_data       = state_reg.rx;
   assign rx_valid      = state_reg.rx_v;
   assign tx_ready      = state_reg.rdy;
   assign tx_slot2_disp = state_reg.disp2;
   assign tx_slot2_ctrl = state_reg.ctrl2;

   chk_tx_split : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && gear4 && tx_valid && tx_ready && !state_reg.phase)
      |=> int_tx_valid && int_tx_data == $past(tx_data[19:0]))
      else $error("first half not sent");
   chk_tx_second : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && gear4 && tx_valid && tx_ready && !state_reg.phase) ##1 (clk_en && gear4)
      |=> int_tx_valid && int_tx_data == $past(tx_data[39:20], 2))
      else $error("second half not sent");
   chk_tx_stall : assert property (@(posedge clk) disable iff (sys_rst)
      state_reg.phase |-> !tx_ready)
      else $error("ready during second half");
   chk_one_byte : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && fabric_width == WIDTH_1B && int_rx_valid)
      |=> rx_valid && rx_data[39:10] == 30'h0)
      else $error("upper bits not cleared");
   chk_two_byte : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && fabric_width == WIDTH_2B && internal_two && tx_valid)
      |=> int_tx_data == $past(tx_data[19:0]))
      else $error("two byte pass wrong");
   chk_flag_map : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && gear4 && tx_valid && tx_ready && !state_reg.phase)
      |=> tx_slot2_disp == $past(tx_data[29]) && tx_slot2_ctrl == $past(tx_data[28]))
      else $error("slot 2 flags wrong");
   cov_gear_tx : cover property (@(posedge clk) gear4 && tx_valid && tx_ready);
   cov_gear_rx : cover property (@(posedge clk) gear4 && rx_valid);
   cov_one_rx  : cover property (@(posedge clk) fabric_width == WIDTH_1B && rx_valid);
   cov_stall   : cover property (@(posedge clk) tx_valid && !tx_ready);
   cov_two_rx  : cover property (@(posedge clk) fabric_width == WIDTH_2B && rx_valid);

   // Joined word leaves the gear one cycle after the joiner presents it
   chk_rx_gear4 : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && gear4 && joined_v)
      |=> rx_valid && rx_data == $past(joined))
      else $error("joined word not forwarded");

   // Two-byte receive keeps the upper half clear
   chk_rx_two : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && fabric_width == WIDTH_2B && internal_two && int_rx_valid)
      |=> rx_valid && rx_data == {20'h0, $past(int_rx_data)})
      else $error("two byte receive wrong");

   // One-byte receive keeps slot 0 intact
   chk_rx_one : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && fabric_width == WIDTH_1B && int_rx_valid)
      |=> rx_data[9:0] == $past(int_rx_data[9:0]))
      else $error("one byte receive wrong");

   // Narrow internal path or one-byte fabric forwards slot 0 only
   chk_tx_narrow : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && !gear4 && tx_valid && (fabric_width == WIDTH_1B || !internal_two))
      |=> int_tx_valid && int_tx_data == {10'h000, $past(tx_data[9:0])})
      else $error("narrow transmit wrong");

   // Ready comes back once the second half has gone
   chk_ready_back : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && state_reg.phase) |=> tx_ready)
      else $error("ready not restored");

   // In four-byte mode the second half follows a pending phase, and the phase then closes
   chk_half_close : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && gear4 && state_reg.phase) |=> int_tx_valid && !state_reg.phase)
      else $error("second half phase stuck");

   // Outside four-byte mode the fabric is never stalled
   chk_ready_narrow : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && !gear4) |=> tx_ready && !state_reg.phase)
      else $error("narrow mode stalled");

   // Slot 2 flags only mean something in four-byte mode
   chk_flag_clear : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && !gear4) |=> !tx_slot2_disp && !tx_slot2_ctrl)
      else $error("slot 2 flags not cleared");

   // No internal word without a fabric word outside gearing
   chk_tx_idle : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && !gear4 && !tx_valid) |=> !int_tx_valid)
      else $error("spurious internal word");

   // No fabric word without an internal word outside gearing
   chk_rx_idle : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && !gear4 && !int_rx_valid) |=> !rx_valid)
      else $error("spurious receive word");
endmodule : fabric_gear
`default_nettype wire

// ===== hdl/gear_pkg.sv
`default_nettype none
package gear_pkg;
   localparam int BUS_W    = 40;
   localparam int SLOT_W   = 10;
   localparam int HALF_W   = 20;
   localparam int DATA_W   = 8;
   localparam int CTRL_POS = 8;   // Control flag within a slot in 8b format
   localparam int DISP_POS = 9;   // Disparity-correction flag within a slot
   // Fabric width codes
   localparam logic [1:0] WIDTH_1B = 2'h0;
   localparam logic [1:0] WIDTH_2B = 2'h1;
   localparam logic [1:0] WIDTH_4B = 2'h2;
   localparam logic [BUS_W-1:0] BUS_RST = 40'h0;
   localparam logic             PHASE_RST = 1'h0;
endpackage : gear_pkg
`default_nettype wire

// ===== hdl/half_if.sv
`default_nettype none
// Two-byte internal word moving between the top and the gear stage
interface half_if;
   logic [19:0] data;
   logic        valid;
   modport src (output data, output valid);
   modport dst (input data, input valid);
endinterface : half_if
`default_nettype wire

// ===== hdl/rx_joiner.sv
`default_nettype none
// Receive 1:2 gear: pairs two internal half words into one fabric word
module rx_joiner
   import gear_pkg::*;
(
   // Clock and control
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             clk_en,
   // Internal side
   half_if.dst                   half_in,
   // Fabric side
   output logic [BUS_W-1:0]      word_out,
   output logic                  word_valid
);
   typedef struct packed {
      logic [HALF_W-1:0] low;
      logic              phase;
      logic [BUS_W-1:0]  word;
      logic              valid;
   } join_state_type;

   join_state_type state_reg, state_next;

   // First half holds slots 0 and 1, second half slots 2 and 3
   always_comb begin
      state_next       = state_reg;
      state_next.valid = 1'b0;
      if (half_in.valid) begin
         if (!state_reg.phase) begin
            state_next.low   = half_in.data;
            state_next.phase = 1'b1;
         end else begin
            state_next.word  = {half_in.data, state_reg.low};
            state_next.valid = 1'b1;
            state_next.phase = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= '0;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   assign word_out   = state_reg.word;
   assign word_valid = state_reg.valid;

   chk_join_pairs : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && half_in.valid && state_reg.phase) |=> word_valid)
      else $error("joined word not presented");
   chk_join_order : assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && half_in.valid && state_reg.phase)
      |=> word_out == {$past(half_in.data), $past(state_reg.low)})
      else $error("joined word order wrong");
endmodule : rx_joiner
`default_nettype wire

// ===== sim/fabric_source.sv
`default_nettype none
// Fabric transmit logic: offers one word and holds it until the gear takes it
module fabric_source
   import gear_pkg::*;
(
   // Clock and mode
   input  wire logic             clk,
   input  wire logic             en,
   input  wire logic [1:0]       width,
   input  wire logic             ready,
   // Requests from the bench
   input  wire logic             start,
   input  wire logic [BUS_W-1:0] word,
   // Fabric transmit bus
   output var logic [BUS_W-1:0]  tx_data,
   output var logic              tx_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic acc;
   initial tx_valid = 1'h0;
   initial tx_data = '0;
   // Same width setting on both sides; a refused word stays put
   assign acc = tx_valid && en && (width != WIDTH_4B || ready);
   // Released bus shows the inverse, so a stale word never looks fresh
   always @(posedge clk) begin
      if (start && (!tx_valid || acc)) begin
         tx_data  <= word;
         tx_valid <= 1'h1;
      end else if (acc) begin
         tx_data  <= ~tx_data;
         tx_valid <= 1'h0;
      end
   end
endmodule : fabric_source
`default_nettype wire

// ===== sim/pcs_fabric_data_bus_gearing_test.sv
`default_nettype none
// Mode table first, then back-to-back four-byte words and a clock-enable freeze
module pcs_fabric_data_bus_gearing_test
   import gear_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [1:0]  w;
      logic        two;
      int          n;
      logic [19:0] e0, e1, ra, rb;
      logic [39:0] rexp;
   } row_type;
   localparam logic [39:0] W1 = 40'h9c3a5b67d1;
   localparam logic [39:0] W2 = 40'h14c1e0b2f3;
   logic        clk, sys_rst, clk_en, internal_two, tx_valid, tx_ready, start;
   logic        int_tx_valid, int_rx_valid, rx_valid, tx_slot2_disp, tx_slot2_ctrl;
   logic [1:0]  fabric_width;
   logic [39:0] tx_data, rx_data, word;
   logic [19:0] int_tx_data, int_rx_data;
   int          fail_count = 0, check_count = 0, cycles = 0, stalls = 0;
   row_type     rows[4];

   fabric_gear i_dut (.clk, .sys_rst, .clk_en, .fabric_width, .internal_two, .tx_data,
      .tx_valid, .tx_ready, .int_tx_data, .int_tx_valid, .int_rx_data, .int_rx_valid,
      .rx_data, .rx_valid, .tx_slot2_disp, .tx_slot2_ctrl);
   fabric_source i_src (.clk, .en(clk_en), .width(fabric_width), .ready(tx_ready),
      .start, .word, .tx_data, .tx_valid);

   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   // Cut a hang short; the whole run needs under a hundred cycles
   always @(posedge clk) begin
      cycles++;
      if (tx_valid === 1'h1 && tx_ready === 1'h0) stalls++;
      if (cycles == 3000) begin
         fail_count++;
         results();
      end
   end

   task check(input logic [39:0] got, input logic [39:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task results;
      if (fail_count == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : results

   // Collect internal transmit words in order; the request is dropped at the first poll
   task drain(input int n, input logic [19:0] e[4]);
      int k;
      k = 0;
      for (int t = 0; t < 16 && k < n; t++) begin
         @(negedge clk);
         start = 1'h0;
         if (int_tx_valid === 1'h1) begin
            check({20'h0, int_tx_data}, {20'h0, e[k]});
            k++;
         end
      end
      check(40'(k), 40'(n));
   endtask : drain

   task send_rx(input logic [19:0] a, input logic [19:0] b, input int n);
      int t;
      @(negedge clk);
      int_rx_data = a;
      int_rx_valid = 1'h1;
      if (n == 2) begin
         @(negedge clk);
         int_rx_data = b;
      end
      @(negedge clk);
      int_rx_valid = 1'h0;
      int_rx_data = ~int_rx_data;
      t = 0;
      while (rx_valid !== 1'h1 && t < 8) begin
         @(negedge clk);
         t++;
      end
      check({39'h0, rx_valid}, 40'h1);
   endtask : send_rx

   initial begin
      rows = '{'{WIDTH_1B, 1'h1, 1, 20'h003d1, 20'h0, 20'h0012c, 20'h0, 40'h12c},
               '{WIDTH_2B, 1'h1, 1, 20'hb67d1, 20'h0, 20'h5a3c1, 20'h0, 40'h5a3c1},
               '{WIDTH_2B, 1'h0, 1, 20'h003d1, 20'h0, 20'h00217, 20'h0, 40'h217},
               '{WIDTH_4B, 1'h1, 2, 20'hb67d1, 20'h9c3a5, 20'h61e0d, 20'h2b9f4,
                 40'h2b9f461e0d}};
      sys_rst = 1'h1;
      clk_en = 1'h1;
      fabric_width = WIDTH_1B;
      internal_two = 1'h1;
      start = 1'h0;
      word = '0;
      int_rx_data = '0;
      int_rx_valid = 1'h0;
      repeat (16) @(negedge clk);
      check({37'h0, tx_ready, int_tx_valid, rx_valid}, 40'h4);
      sys_rst = 1'h0;
      // One row per width, two for two-byte: transmit, then receive; only the four-byte row splits and joins
      foreach (rows[i]) begin
         @(negedge clk);
         fabric_width = rows[i].w;
         internal_two = rows[i].two;
         start = 1'h1;
         word = W1;
         drain(rows[i].n, '{rows[i].e0, rows[i].e1, 20'h0, 20'h0});
         send_rx(rows[i].ra, rows[i].rb, rows[i].n);
         check(rx_data, rows[i].rexp);
      end
      check({38'h0, tx_slot2_disp, tx_slot2_ctrl}, {38'h0, W1[29:28]});
      // Second word offered while the gear still sends the first half
      @(negedge clk);
      start = 1'h1;
      word = W1;
      @(negedge clk);
      word = W2;
      drain(4, '{W1[19:0], W1[39:20], W2[19:0], W2[39:20]});
      check(40'(stalls > 0), 40'h1);
      check({38'h0, tx_slot2_disp, tx_slot2_ctrl}, {38'h0, W2[29:28]});
      // Frozen clock enable must hold the offered word back
      @(negedge clk);
      clk_en = 1'h0;
      start = 1'h1;
      repeat (4) begin
         @(negedge clk);
         start = 1'h0;
         check({39'h0, int_tx_valid}, 40'h0);
      end
      clk_en = 1'h1;
      drain(2, '{W2[19:0], W2[39:20], 20'h0, 20'h0});
      results();
   end
endmodule : pcs_fabric_data_bus_gearing_test
`default_nettype wire
